// *** diag_pkg.sv ***
// ----------------------------------------
// How it works
// ----------------------------------------
// How it works
// - apply bit drives switches on where pattern bit set, off where clear.
// - apply acts only while balancing is stopped or paused.
// - applied switch states give way to balancing once it starts or resumes.
// - sink select takes effect at once: off, cell pins, balance pins, shunt source.
// - select field is sampled only when start is written 1.
// - code 000 and undefined codes run no comparison.
// - code 001 checks main-aux cell delta below threshold, sets cell done.
// - code 010 checks active cell readings below open-wire threshold, sets done.
// - code 011 checks aux balance-pin readings below open-wire threshold, sets done.
// - code 100 drives pattern switches while balancing is stopped, checks aux below main third, sets done.
// - after switch check, hold keeps pattern, otherwise all switches turn off.
// - code 101 checks gpio main-aux delta below threshold, sets gpio done.
// - start bit always reads 0; writing 0 does nothing.
// - comparison fault inject forces every comparison run to fail.
// - filter fault inject forces the filter fail flag.
// - cell delta passes below threshold of 6 mV plus 3 mV steps.
// - open-wire threshold 4 bits, 500 mV plus 300 mV steps, shared.
package diag_pkg;
  localparam int NCH = 16;
  localparam int NGPIO = 8;
  localparam int AW = 12;
  localparam logic [AW-1:0] ADDR_CMP_CTRL = 12'h33C;
  localparam logic [AW-1:0] ADDR_FINJ_CTRL = 12'h33D;
  localparam logic [AW-1:0] ADDR_PROT_CTRL = 12'h33E;
  localparam logic [AW-1:0] ADDR_THR_CTRL = 12'h340;
  localparam logic [AW-1:0] ADDR_PATTERN = 12'h344;
  localparam logic [AW-1:0] ADDR_CHSEL = 12'h348;
  localparam logic [AW-1:0] ADDR_STATUS = 12'h34C;
  localparam logic [AW-1:0] ADDR_RESULT = 12'h350;
  localparam int B_START = 0;
  localparam int B_SEL_LO = 1;
  localparam int B_SINK_LO = 4;
  localparam int B_APPLY = 6;
  localparam int B_FILT_INJ = 4;
  localparam int B_CMP_INJ = 5;
  localparam int B_LATCH = 0;
  localparam int B_HOLD = 15;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CELL = 3'h1;
  localparam logic [2:0] SEL_CPOW = 3'h2;
  localparam logic [2:0] SEL_BPOW = 3'h3;
  localparam logic [2:0] SEL_SW = 3'h4;
  localparam logic [2:0] SEL_GPIO = 3'h5;
  localparam logic [1:0] SINK_OFF = 2'h0;
  localparam logic [1:0] SINK_CELL = 2'h1;
  localparam logic [1:0] SINK_BAL = 2'h2;
  localparam logic [1:0] SINK_SHUNT = 2'h3;
  // thresholds in mV, code scaled: base + code * step
  localparam logic [15:0] CELL_THR_BASE = 16'h0006;
  localparam logic [15:0] CELL_THR_STEP = 16'h0003;
  localparam logic [15:0] OPEN_WIRE_THRESHOLD_BASE = 16'h01F4;
  localparam logic [15:0] OPEN_WIRE_THRESHOLD_STEP = 16'h012C;
  localparam logic [15:0] GPIO_DELTA_THRESHOLD_BASE = 16'h0004;
  localparam logic [15:0] GPIO_DELTA_THRESHOLD_STEP = 16'h0004;
  localparam logic [1:0] MUL_THIRD = 2'h3;
  typedef enum {ST_IDLE, ST_SETTLE, ST_RUN, ST_DONE} cmp_state_t;
endpackage : diag_pkg

// *** diag_compare_unit.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// per-channel comparison, all readings in mV
// ----------------------------------------
module diag_compare_unit
  import diag_pkg::*;
(
  input wire logic [2:0] sel,
  input wire logic [15:0] main_mv,
  input wire logic [15:0] aux_mv,
  input wire logic [15:0] cell_thr_mv,
  input wire logic [15:0] open_wire_threshold_mv,
  input wire logic [15:0] gpio_delta_threshold_mv,
  input wire logic chosen,
  output logic fail
);
  logic [15:0] delta;
  logic [17:0] aux_x3;
  always_comb begin
    delta = (main_mv > aux_mv) ? (main_mv - aux_mv) : (aux_mv - main_mv);
    aux_x3 = 18'(aux_mv) * 18'(MUL_THIRD);
    fail = 1'b0;
    if (chosen) begin
      unique case (sel)
        SEL_CELL: fail = !(delta < cell_thr_mv);
        SEL_CPOW: fail = !(main_mv < open_wire_threshold_mv);
        SEL_BPOW: fail = !(aux_mv < open_wire_threshold_mv);
        SEL_SW: fail = !(aux_x3 < 18'(main_mv));
        SEL_GPIO: fail = !(delta < gpio_delta_threshold_mv);
        default: fail = 1'b0;
      endcase
    end
  end
endmodule : diag_compare_unit

// *** diag_control.sv ***
`timescale 1ns/1ps
module diag_control
  import diag_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BALANCING_ACTIVE,
  input wire logic [NCH-1:0] BALANCING_SWITCH_REQ,
  input wire logic [NCH*16-1:0] MAIN_CELL_READING,
  input wire logic [NCH*16-1:0] AUX_CELL_READING,
  input wire logic [NGPIO*16-1:0] MAIN_GPIO_READING,
  input wire logic [NGPIO*16-1:0] AUX_GPIO_READING,
  input wire logic [NCH-1:0] ACTIVE_CELLS,
  input wire logic [NGPIO-1:0] GPIO_ADC_EN,
  input wire logic FILTER_CHECK_FAIL,
  input wire logic PROT_FAULT_DETECT,
  input wire logic PROT_CHANNEL_STEP,
  output logic [NCH-1:0] BALANCE_SWITCH,
  output logic CELL_SINK_EN,
  output logic BAL_SINK_EN,
  output logic SHUNT_SOURCE_EN,
  output logic FILTER_FAIL_FLAG,
  output logic FAULT_OUT_N
);
  logic [7:0] cmp_ctrl_reg;
  logic [7:0] finj_reg;
  logic [7:0] prot_reg;
  logic [15:0] thr_reg;
  logic [NCH-1:0] pattern_reg;
  logic [NCH-1:0] chsel_reg;
  logic [4:0] done_reg;
  logic [4:0] pass_reg;
  logic [NCH-1:0] sw_reg;
  logic applied_reg;
  logic [2:0] run_sel_reg;
  logic prot_fault_reg;
  logic bal_prev_reg;
  cmp_state_t state_reg;
  logic wr_en;
  logic rd_en;
  logic start_wr;
  logic mapped;
  logic [4:0] done_set;
  logic any_fail;
  logic [NCH-1:0] cell_fail;
  logic [NGPIO-1:0] gpio_fail;
  logic [15:0] cell_thr_mv;
  logic [15:0] open_wire_threshold_mv;
  logic [15:0] gpio_delta_threshold_mv;
  logic [AW-1:0] reg_idx;
  logic status_rd;
  logic [4:0] done_clr;

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  // register constants are word indices; a misaligned byte address decodes to nothing
  assign reg_idx = (PADDR[1:0] == 2'h0) ? {2'h0, PADDR[AW-1:2]} : {AW{1'b1}};
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign status_rd = rd_en && (reg_idx == ADDR_STATUS);
  assign start_wr = wr_en && (reg_idx == ADDR_CMP_CTRL) && PWDATA[B_START];
  assign mapped = (reg_idx == ADDR_CMP_CTRL) || (reg_idx == ADDR_FINJ_CTRL) || (reg_idx == ADDR_PROT_CTRL)
    || (reg_idx == ADDR_THR_CTRL) || (reg_idx == ADDR_PATTERN) || (reg_idx == ADDR_CHSEL)
    || (reg_idx == ADDR_STATUS) || (reg_idx == ADDR_RESULT);

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cmp_ctrl_reg <= RST_BYTE;
      finj_reg <= RST_BYTE;
      prot_reg <= RST_BYTE;
      thr_reg <= RST_WORD[15:0];
      pattern_reg <= RST_WORD[NCH-1:0];
      chsel_reg <= RST_WORD[NCH-1:0];
    end else if (wr_en) begin
      unique case (reg_idx)
        // start and apply are actions, never stored as ones
        ADDR_CMP_CTRL: cmp_ctrl_reg <= {2'h0, PWDATA[B_SINK_LO +: 2], PWDATA[B_SEL_LO +: 3], 1'b0};
        ADDR_FINJ_CTRL: finj_reg <= {2'h0, PWDATA[B_CMP_INJ], PWDATA[B_FILT_INJ], 4'h0};
        ADDR_PROT_CTRL: prot_reg <= {7'h00, PWDATA[B_LATCH]};
        ADDR_THR_CTRL: thr_reg <= PWDATA[15:0];
        ADDR_PATTERN: pattern_reg <= PWDATA[NCH-1:0];
        ADDR_CHSEL: chsel_reg <= PWDATA[NCH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PRDATA <= RST_WORD;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA <= RST_WORD;
      if (PSEL && !PENABLE && !PWRITE) begin
        unique case (reg_idx)
          ADDR_CMP_CTRL: PRDATA <= {24'h0, cmp_ctrl_reg};
          ADDR_FINJ_CTRL: PRDATA <= {24'h0, finj_reg};
          ADDR_PROT_CTRL: PRDATA <= {24'h0, prot_reg};
          ADDR_THR_CTRL: PRDATA <= {16'h0, thr_reg};
          ADDR_PATTERN: PRDATA <= {16'h0, pattern_reg};
          ADDR_CHSEL: PRDATA <= {16'h0, chsel_reg};
          ADDR_STATUS: PRDATA <= {24'h0, FILTER_FAIL_FLAG, (state_reg != ST_IDLE), applied_reg, done_reg};
          ADDR_RESULT: PRDATA <= {27'h0, pass_reg};
          default: PRDATA <= RST_WORD;
        endcase
      end
    end
  end

  // ----------------------------------------
  // threshold scaling
  // ----------------------------------------
  assign cell_thr_mv = CELL_THR_BASE + 16'(thr_reg[4:0]) * CELL_THR_STEP;
  assign open_wire_threshold_mv = OPEN_WIRE_THRESHOLD_BASE + 16'(thr_reg[11:8]) * OPEN_WIRE_THRESHOLD_STEP;
  assign gpio_delta_threshold_mv = GPIO_DELTA_THRESHOLD_BASE + 16'(thr_reg[14:12]) * GPIO_DELTA_THRESHOLD_STEP;

  // ----------------------------------------
  // per-channel comparators
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_cell
      diag_compare_unit u_cmp (
        .sel(run_sel_reg),
        .main_mv(MAIN_CELL_READING[g*16 +: 16]),
        .aux_mv(AUX_CELL_READING[g*16 +: 16]),
        .cell_thr_mv(cell_thr_mv),
        .open_wire_threshold_mv(open_wire_threshold_mv),
        .gpio_delta_threshold_mv(gpio_delta_threshold_mv),
        .chosen((run_sel_reg == SEL_CPOW) ? ACTIVE_CELLS[g] : chsel_reg[g]),
        .fail(cell_fail[g])
      );
    end
    for (g = 0; g < NGPIO; g++) begin : g_gpio
      diag_compare_unit u_cmp (
        .sel((run_sel_reg == SEL_GPIO) ? SEL_GPIO : SEL_NONE),
        .main_mv(MAIN_GPIO_READING[g*16 +: 16]),
        .aux_mv(AUX_GPIO_READING[g*16 +: 16]),
        .cell_thr_mv(cell_thr_mv),
        .open_wire_threshold_mv(open_wire_threshold_mv),
        .gpio_delta_threshold_mv(gpio_delta_threshold_mv),
        .chosen(GPIO_ADC_EN[g]),
        .fail(gpio_fail[g])
      );
    end
  endgenerate

  assign any_fail = (run_sel_reg == SEL_GPIO) ? (|gpio_fail) : (|cell_fail);

  // ----------------------------------------
  // comparison sequencer
  // ----------------------------------------
  // settle cycle loads sw_reg; BALANCE_SWITCH takes it at the edge where the switch check samples
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      run_sel_reg <= SEL_NONE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (start_wr) begin
          run_sel_reg <= PWDATA[B_SEL_LO +: 3];
          state_reg <= ST_SETTLE;
        end
        ST_SETTLE: state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_DONE;
        ST_DONE: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    done_set = 5'h00;
    if (state_reg == ST_RUN) begin
      unique case (run_sel_reg)
        SEL_CELL: done_set[0] = 1'b1;
        SEL_CPOW: done_set[1] = 1'b1;
        SEL_BPOW: done_set[2] = 1'b1;
        SEL_SW: done_set[3] = 1'b1;
        SEL_GPIO: done_set[4] = 1'b1;
        default: done_set = 5'h00;
      endcase
    end
  end

  // read word is latched a cycle before the access edge; clearing only the
  // flags it showed keeps a flag set in between from being lost unseen
  always_comb begin
    done_clr = 5'h00;
    if (status_rd) begin
      done_clr = PRDATA[4:0];
    end
  end

  // done flags clear on a status read; a new set wins over the clear
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      done_reg <= 5'h00;
      pass_reg <= 5'h00;
    end else begin
      done_reg <= (done_reg & ~done_clr) | done_set;
      for (int i = 0; i < 5; i++) begin
        if (done_set[i]) begin
          pass_reg[i] <= !any_fail && !finj_reg[B_CMP_INJ];
        end
      end
    end
  end

  // ----------------------------------------
  // balance switch control and sinks
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sw_reg <= RST_WORD[NCH-1:0];
      applied_reg <= 1'b0;
      bal_prev_reg <= 1'b0;
      BALANCE_SWITCH <= RST_WORD[NCH-1:0];
    end else begin
      bal_prev_reg <= BALANCING_ACTIVE;
      if (BALANCING_ACTIVE && !bal_prev_reg) begin
        applied_reg <= 1'b0;
      end else if (!BALANCING_ACTIVE && wr_en && reg_idx == ADDR_CMP_CTRL && PWDATA[B_APPLY]) begin
        sw_reg <= pattern_reg;
        applied_reg <= 1'b1;
      end else if (!BALANCING_ACTIVE && state_reg == ST_SETTLE && run_sel_reg == SEL_SW) begin
        sw_reg <= pattern_reg;
        applied_reg <= 1'b1;
      end else if (state_reg == ST_DONE && run_sel_reg == SEL_SW && !thr_reg[B_HOLD]) begin
        sw_reg <= RST_WORD[NCH-1:0];
        applied_reg <= 1'b0;
      end
      BALANCE_SWITCH <= BALANCING_ACTIVE ? BALANCING_SWITCH_REQ : (applied_reg ? sw_reg : RST_WORD[NCH-1:0]);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      CELL_SINK_EN <= 1'b0;
      BAL_SINK_EN <= 1'b0;
      SHUNT_SOURCE_EN <= 1'b0;
    end else begin
      CELL_SINK_EN <= cmp_ctrl_reg[B_SINK_LO +: 2] == SINK_CELL;
      BAL_SINK_EN <= cmp_ctrl_reg[B_SINK_LO +: 2] == SINK_BAL;
      SHUNT_SOURCE_EN <= cmp_ctrl_reg[B_SINK_LO +: 2] == SINK_SHUNT;
    end
  end

  // ----------------------------------------
  // filter and protector fault injection
  // ----------------------------------------
  // latch 0 lets the channel step release the injected fault
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      FILTER_FAIL_FLAG <= 1'b0;
      prot_fault_reg <= 1'b0;
      FAULT_OUT_N <= 1'b1;
    end else begin
      FILTER_FAIL_FLAG <= FILTER_CHECK_FAIL || finj_reg[B_FILT_INJ];
      if (PROT_FAULT_DETECT) begin
        prot_fault_reg <= 1'b1;
      end else if (PROT_CHANNEL_STEP && !prot_reg[B_LATCH]) begin
        prot_fault_reg <= 1'b0;
      end
      FAULT_OUT_N <= !(prot_fault_reg || PROT_FAULT_DETECT);
    end
  end
endmodule : diag_control

// *** diag_control_chk.sv ***
`timescale 1ns/1ps
// ----
// port checks
// ----
module diag_control_chk
  import diag_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BALANCING_ACTIVE,
  input wire logic [NCH-1:0] BALANCING_SWITCH_REQ,
  input wire logic FILTER_CHECK_FAIL,
  input wire logic PROT_FAULT_DETECT,
  input wire logic PROT_CHANNEL_STEP,
  input wire logic [NCH-1:0] BALANCE_SWITCH,
  input wire logic CELL_SINK_EN,
  input wire logic BAL_SINK_EN,
  input wire logic SHUNT_SOURCE_EN,
  input wire logic FILTER_FAIL_FLAG,
  input wire logic FAULT_OUT_N
);
  logic wr;
  logic mapped;
  logic [1:0] sink_w;
  logic [15:0] pat_q;
  logic finj_q;
  logic lat_q;
  logic [AW-1:0] idx;
  assign idx = (PADDR[1:0] == 2'h0) ? {2'h0, PADDR[AW-1:2]} : {AW{1'b1}};
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign mapped = idx inside {ADDR_CMP_CTRL, ADDR_FINJ_CTRL, ADDR_PROT_CTRL, ADDR_THR_CTRL,
    ADDR_PATTERN, ADDR_CHSEL, ADDR_STATUS, ADDR_RESULT};
  // shadow copies of the control fields, taken at the accepting edge
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sink_w <= SINK_OFF;
      pat_q <= 16'h0000;
      finj_q <= 1'b0;
      lat_q <= 1'b0;
    end else if (wr) begin
      if (idx == ADDR_CMP_CTRL) sink_w <= PWDATA[5:4];
      if (idx == ADDR_PATTERN) pat_q <= PWDATA[15:0];
      if (idx == ADDR_FINJ_CTRL) finj_q <= PWDATA[B_FILT_INJ];
      if (idx == ADDR_PROT_CTRL) lat_q <= PWDATA[B_LATCH];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_apply;
    wr && idx == ADDR_CMP_CTRL && PWDATA[B_APPLY] && !BALANCING_ACTIVE;
  endsequence
  AST_ZERO_WAIT: assert property (s_setup |=> PREADY) else $error("no ready in access");
  AST_SLVERR: assert property (PREADY |-> PSLVERR == !mapped) else $error("bad error flag");
  AST_START_RD0: assert property (PREADY && !PWRITE && idx == ADDR_CMP_CTRL |-> !PRDATA[B_START])
    else $error("start bit read as one");
  AST_SINK: assert property (wr && idx == ADDR_CMP_CTRL |-> ##[1:2]
    {SHUNT_SOURCE_EN, BAL_SINK_EN, CELL_SINK_EN} == {sink_w == SINK_SHUNT, sink_w == SINK_BAL, sink_w == SINK_CELL})
    else $error("sink enables wrong");
  AST_APPLY: assert property (s_apply |-> ##[1:2] BALANCE_SWITCH == pat_q) else $error("pattern not applied");
  AST_BAL_OWNS: assert property (!$past(SYS_RST) && !$past(SYS_RST, 2) && $past(BALANCING_ACTIVE)
    && $past(BALANCING_ACTIVE, 2) |-> BALANCE_SWITCH == $past(BALANCING_SWITCH_REQ)) else $error("switch owner");
  AST_FILTER: assert property (!$past(SYS_RST) |->
    FILTER_FAIL_FLAG == ($past(FILTER_CHECK_FAIL) || $past(finj_q))) else $error("filter flag wrong");
  AST_FAULT_SET: assert property (PROT_FAULT_DETECT |=> !FAULT_OUT_N) else $error("fault not shown");
  AST_FAULT_REL: assert property (!lat_q && PROT_CHANNEL_STEP && !PROT_FAULT_DETECT ##1 !PROT_FAULT_DETECT
    |=> FAULT_OUT_N)
    else $error("fault not released");
  AST_FAULT_HOLD: assert property (lat_q && !FAULT_OUT_N |=> !FAULT_OUT_N) else $error("latched fault lost");
endmodule : diag_control_chk
bind diag_control diag_control_chk diag_control_chk_inst (.*);

// *** diag_host_model.sv ***
`timescale 1ns/1ps
// ----
// host bus master
// ----
module diag_host_model
  import diag_pkg::*;
(
  input wire logic REF_CLK,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [AW-1:0] PADDR,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
  end
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    // a is a word index; the bus carries its byte address
    PADDR <= {a[AW-3:0], 2'h0};
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    // no cycle budget here: only the bench watchdog ends a hung wait
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // released data lines flip so stale values never look valid
    PWDATA <= ~d;
  endtask : xfer
endmodule : diag_host_model

// *** diag_control_tb.sv ***
`timescale 1ns/1ps
// ----
// scenarios
// ----
module diag_control_tb
  import diag_pkg::*;
;
  logic REF_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BALANCING_ACTIVE;
  logic FILTER_CHECK_FAIL, PROT_FAULT_DETECT, PROT_CHANNEL_STEP, CELL_SINK_EN, BAL_SINK_EN;
  logic SHUNT_SOURCE_EN, FILTER_FAIL_FLAG, FAULT_OUT_N;
  logic [AW-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [NCH-1:0] BALANCING_SWITCH_REQ, ACTIVE_CELLS, BALANCE_SWITCH;
  logic [NCH*16-1:0] MAIN_CELL_READING, AUX_CELL_READING;
  logic [NGPIO*16-1:0] MAIN_GPIO_READING, AUX_GPIO_READING;
  logic [NGPIO-1:0] GPIO_ADC_EN;
  int n_mismatch = 0;
  int check_count = 0;
  diag_control diag_control_inst (.*);
  diag_host_model diag_host_model_inst (.*);
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask : cmp_pin
  task automatic cmp_reg(input logic [AW-1:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
    logic [31:0] q;
    logic e;
    diag_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
    cmp_pin(q & m, x, s);
  endtask : cmp_reg
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    diag_host_model_inst.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic run(input logic [2:0] c, input logic [1:0] s, output logic [31:0] q);
    logic e;
    int n;
    wr(ADDR_CMP_CTRL, {26'h0, s, c, 1'b1});
    n = 0;
    do begin
      diag_host_model_inst.xfer(1'b0, ADDR_STATUS, 32'h0, q, e);
      n++;
    end while (q[4:0] === 5'h00 && n < 6);
  endtask : run
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    cmp_pin({11'h0, FAULT_OUT_N, FILTER_FAIL_FLAG, SHUNT_SOURCE_EN, BAL_SINK_EN, CELL_SINK_EN, BALANCE_SWITCH},
      32'h0010_0000, "reset pins");
    cmp_reg(ADDR_FINJ_CTRL, 32'hFF, 32'h0, "inject reset");
    cmp_reg(ADDR_PROT_CTRL, 32'hFF, 32'h0, "latch reset");
    diag_host_model_inst.xfer(1'b0, 12'h334, 32'h0, q, e);
    cmp_pin({q[31:1], e}, 32'h1, "unmapped read");
    $display("reset test done");
  endtask : t_reset
  task automatic t_sink;
    logic [2:0] x [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    for (int k = 3; k >= 0; k--) begin
      wr(ADDR_CMP_CTRL, {26'h0, k[1:0], 4'h0});
      repeat (2) @(posedge REF_CLK);
      cmp_pin({29'h0, SHUNT_SOURCE_EN, BAL_SINK_EN, CELL_SINK_EN}, {29'h0, x[k]}, "sink");
    end
    $display("sink test done");
  endtask : t_sink
  task automatic t_compare;
    logic [31:0] q;
    wr(ADDR_CHSEL, 32'h0000_FFFF);
    wr(ADDR_THR_CTRL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      if (i != 4) begin
        run(i[2:0], (i == 2) ? SINK_CELL : (i == 3) ? SINK_BAL : SINK_OFF, q);
        cmp_pin({27'h0, q[4:0]}, (i > 0 && i < 6) ? 32'h1 << (i - 1) : 32'h0, "done");
      end
    end
    cmp_reg(ADDR_RESULT, 32'h11, 32'h11, "pass");
    AUX_CELL_READING <= {NCH{16'h0BBE}};
    run(SEL_CELL, SINK_OFF, q);
    cmp_reg(ADDR_RESULT, 32'h1, 32'h0, "delta at limit");
    wr(ADDR_THR_CTRL, 32'h1);
    run(SEL_CELL, SINK_OFF, q);
    cmp_reg(ADDR_RESULT, 32'h1, 32'h1, "delta below");
    wr(ADDR_FINJ_CTRL, 32'h20);
    run(SEL_CELL, SINK_OFF, q);
    cmp_reg(ADDR_RESULT, 32'h1, 32'h0, "injected");
    wr(ADDR_FINJ_CTRL, 32'h0);
    wr(ADDR_CMP_CTRL, 32'h2);
    // room for a wrongly started run to post its flag
    repeat (4) @(posedge REF_CLK);
    cmp_reg(ADDR_STATUS, 32'h1F, 32'h0, "no start");
    cmp_reg(ADDR_CMP_CTRL, 32'h41, 32'h0, "start reads 0");
    $display("compare test done");
  endtask : t_compare
  task automatic t_switch;
    logic [31:0] q;
    wr(ADDR_PATTERN, 32'h00A5);
    for (int h = 1; h >= 0; h--) begin
      wr(ADDR_THR_CTRL, {16'h0, h[0], 15'h1});
      run(SEL_SW, SINK_OFF, q);
      cmp_pin({27'h0, q[4:0]}, 32'h8, "switch done");
      cmp_pin({16'h0, BALANCE_SWITCH}, (h != 0) ? 32'hA5 : 32'h0, "after check");
    end
    $display("switch test done");
  endtask : t_switch
  task automatic t_apply;
    wr(ADDR_PATTERN, 32'h5A5A);
    wr(ADDR_CMP_CTRL, 32'h40);
    repeat (3) @(posedge REF_CLK);
    cmp_pin({16'h0, BALANCE_SWITCH}, 32'h5A5A, "applied");
    BALANCING_SWITCH_REQ <= 16'h0F0F;
    BALANCING_ACTIVE <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    cmp_pin({16'h0, BALANCE_SWITCH}, 32'h0F0F, "resumed");
    wr(ADDR_PATTERN, 32'hFFFF);
    wr(ADDR_CMP_CTRL, 32'h40);
    repeat (3) @(posedge REF_CLK);
    cmp_pin({16'h0, BALANCE_SWITCH}, 32'h0F0F, "apply refused");
    BALANCING_ACTIVE <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    cmp_pin({16'h0, BALANCE_SWITCH}, 32'h0, "pattern not restored");
    $display("apply test done");
  endtask : t_apply
  task automatic t_filter;
    wr(ADDR_FINJ_CTRL, 32'h10);
    cmp_reg(ADDR_FINJ_CTRL, 32'hFF, 32'h10, "inject rw");
    cmp_pin({31'h0, FILTER_FAIL_FLAG}, 32'h1, "filter inject");
    wr(ADDR_FINJ_CTRL, 32'h0);
    FILTER_CHECK_FAIL <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    cmp_pin({31'h0, FILTER_FAIL_FLAG}, 32'h1, "filter fail");
    FILTER_CHECK_FAIL <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    cmp_pin({31'h0, FILTER_FAIL_FLAG}, 32'h0, "filter clear");
    $display("filter test done");
  endtask : t_filter
  task automatic t_prot;
    for (int l = 0; l < 2; l++) begin
      wr(ADDR_PROT_CTRL, {31'h0, l[0]});
      PROT_FAULT_DETECT <= 1'b1;
      @(posedge REF_CLK);
      PROT_FAULT_DETECT <= 1'b0;
      repeat (2) @(posedge REF_CLK);
      cmp_pin({31'h0, FAULT_OUT_N}, 32'h0, "fault shown");
      PROT_CHANNEL_STEP <= 1'b1;
      @(posedge REF_CLK);
      PROT_CHANNEL_STEP <= 1'b0;
      repeat (2) @(posedge REF_CLK);
      cmp_pin({31'h0, FAULT_OUT_N}, {31'h0, ~l[0]}, "after step");
    end
    // second reset mid-run clears the latched fault and the latch bit
    SYS_RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    cmp_reg(ADDR_PROT_CTRL, 32'hFF, 32'h0, "latch reset");
    cmp_pin({31'h0, FAULT_OUT_N}, 32'h1, "fault released");
    $display("protector test done");
  endtask : t_prot
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    SYS_RST = 1'b1;
    BALANCING_ACTIVE = 1'b0;
    BALANCING_SWITCH_REQ = 16'h0000;
    FILTER_CHECK_FAIL = 1'b0;
    PROT_FAULT_DETECT = 1'b0;
    PROT_CHANNEL_STEP = 1'b0;
    ACTIVE_CELLS = 16'hFFFF;
    GPIO_ADC_EN = 8'hFF;
    MAIN_CELL_READING = {NCH{16'h0BB8}};
    AUX_CELL_READING = {NCH{16'h0BB8}};
    MAIN_GPIO_READING = {NGPIO{16'h0320}};
    AUX_GPIO_READING = {NGPIO{16'h0320}};
    repeat (12) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_sink();
    t_compare();
    t_switch();
    t_apply();
    t_filter();
    t_prot();
    results();
  end
endmodule : diag_control_tb
